//--- design/svm_params.svh
/*
  Constants for the supply voltage monitor control block: register
  offsets, field positions and reset values. Assumes 8-bit register data
  and a 12-bit register address.
*/
`ifndef SVM_PARAMS_SVH
`define SVM_PARAMS_SVH
`define SVM_ADDR_W 12
`define SVM_DATA_W 8
`define SVM_CHANS 2
`define SVM_OFS_LVL 12'hfc6
`define SVM_OFS_MODE 12'hfc7
`define SVM_LVL_LSB 0
`define SVM_LIVE_BIT 2
`define SVM_STK_BIT 3
`define SVM_LVL_STRIDE 4
`define SVM_EN_BIT 0
`define SVM_MOD_BIT 1
`define SVM_MODE_STRIDE 2
`define SVM_RSV_LSB 4
`define SVM_LVL1_RST 2'h0
`define SVM_LVL2_RST 2'h2
`endif

//--- design/svm_pkg.sv
/*
  Types for the supply voltage monitor control block. Assumes the
  constants header is on the include path.
*/
`include "svm_params.svh"
package svm_pkg;
  typedef enum logic [1:0] {
    LP_RUN = 2'h0,
    LP_IDLE_SLEEP = 2'h1,
    LP_STOP = 2'h3
  } lp_e;
  typedef struct packed {
    logic [`SVM_ADDR_W-1:0] addr;
    logic [`SVM_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] filt;
    logic [1:0] filt_prev;
    logic [1:0] en_prev;
    logic [1:0][1:0] lvl;
    logic [1:0] sticky;
    logic [1:0] live;
    logic [1:0] mode;
    logic [1:0] en;
    logic [1:0] rsv;
    logic [1:0] pend;
    logic irq;
    logic vrst;
    logic [`SVM_DATA_W-1:0] rdata;
  } state_s;
endpackage

//--- design/supply_voltage_monitor_ctrl.sv
/*
  Digital control of a two-channel supply voltage monitor: threshold
  selects, enables, mode bits, sticky and live flags, shared interrupt
  pulse and detection reset. Assumes reset_n is driven only by power-on
  or external reset, comparator outputs are asynchronous, and the
  low-power state input comes from logic on clk.
*/
`timescale 1ns/1ns
`include "svm_params.svh"
module supply_voltage_monitor_ctrl
  import svm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire reg_req_s req,
  output logic [`SVM_DATA_W-1:0] rdata,
  // Analog comparators.
  input wire logic [1:0] cmp_below,
  output logic [1:0] chan_monitor_on,
  output logic [1:0] chan1_threshold_sel,
  output logic [1:0] chan2_threshold_sel,
  // System control.
  input wire lp_e lp_state,
  output logic supply_low_irq,
  output logic vdet_reset
);

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  state_s q;
  state_s d;
  logic run;
  logic wr_lvl;
  logic wr_mode;
  logic rd_lvl;
  logic rd_mode;
  logic [1:0] ev;
  logic [1:0] set;
  logic [1:0] clr;
  logic [`SVM_DATA_W-1:0] r1;
  logic [`SVM_DATA_W-1:0] r2;

  function automatic logic reg_hit(input logic [`SVM_ADDR_W-1:0] a,
                                   input logic [`SVM_ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    set = '0;
    clr = '0;
    r1 = '0;
    r2 = '0;
    run = (lp_state == LP_RUN);
    wr_lvl = req.wr && reg_hit(req.addr, `SVM_OFS_LVL);
    wr_mode = req.wr && reg_hit(req.addr, `SVM_OFS_MODE);
    rd_lvl = req.rd && reg_hit(req.addr, `SVM_OFS_LVL);
    rd_mode = req.rd && reg_hit(req.addr, `SVM_OFS_MODE);
    d.sync1 = cmp_below;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.filt_prev = q.filt;
    d.en_prev = q.en;
    for (int i = 0; i < `SVM_CHANS; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        d.filt[i] = q.sync3[i];
      end
      set[i] = run && q.en[i] && q.filt[i];
      clr[i] = wr_lvl && !req.wdata[`SVM_STK_BIT + `SVM_LVL_STRIDE * i];
      d.sticky[i] = (q.sticky[i] && !clr[i]) || set[i];
      if (run) begin
        d.live[i] = q.en[i] && q.filt[i];
      end
      ev[i] = q.en[i] && !q.mode[i] &&
              ((q.filt[i] != q.filt_prev[i]) ||
               (!q.en_prev[i] && q.filt[i]));
      if (wr_lvl) begin
        d.lvl[i] = req.wdata[`SVM_LVL_LSB + `SVM_LVL_STRIDE * i +: 2];
      end
      if (wr_mode) begin
        d.en[i] = req.wdata[`SVM_EN_BIT + `SVM_MODE_STRIDE * i];
        d.mode[i] = req.wdata[`SVM_MOD_BIT + `SVM_MODE_STRIDE * i];
      end
      r1[`SVM_LVL_LSB + `SVM_LVL_STRIDE * i +: 2] = q.lvl[i];
      r1[`SVM_LIVE_BIT + `SVM_LVL_STRIDE * i] = q.live[i];
      r1[`SVM_STK_BIT + `SVM_LVL_STRIDE * i] = q.sticky[i];
      r2[`SVM_EN_BIT + `SVM_MODE_STRIDE * i] = q.en[i];
      r2[`SVM_MOD_BIT + `SVM_MODE_STRIDE * i] = q.mode[i];
    end
    if (wr_mode) begin
      d.rsv = req.wdata[`SVM_RSV_LSB +: 2];
    end
    r2[`SVM_RSV_LSB +: 2] = q.rsv;
    // shared interrupt deferred in low power
    if (run) begin
      d.irq = |(ev | q.pend);
      d.pend = '0;
    end else begin
      d.irq = 1'b0;
      d.pend = q.pend | ev;
    end
    d.vrst = |(q.en & q.mode & q.filt);
    if (rd_lvl) begin
      d.rdata = r1;
    end else if (rd_mode) begin
      d.rdata = r2;
    end else begin
      d.rdata = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // only the power-on or external reset clears
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.lvl[0] <= `SVM_LVL1_RST;
      q.lvl[1] <= `SVM_LVL2_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign chan_monitor_on = q.en;
  assign chan1_threshold_sel = q.lvl[0];
  assign chan2_threshold_sel = q.lvl[1];
  assign supply_low_irq = q.irq;
  assign vdet_reset = q.vrst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_sticky_set;
    @(posedge clk) disable iff (!reset_n)
    (run && q.en[0] && q.filt[0]) |=> q.sticky[0];
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("sticky flag not set on detection");

  property p_no_sw_set;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.sticky[1]) |-> $past(run && q.en[1] && q.filt[1]);
  endproperty
  a_no_sw_set: assert property (p_no_sw_set)
    else $error("sticky flag set without detection");

  property p_set_wins;
    @(posedge clk) disable iff (!reset_n)
    (set[0] && clr[0]) |=> q.sticky[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous detection");

  property p_live;
    @(posedge clk) disable iff (!reset_n)
    run |=> (q.live[1] == $past(q.en[1] && q.filt[1]));
  endproperty
  a_live: assert property (p_live)
    else $error("live status does not follow comparator");

  property p_lead;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.live[0]) |-> ##[0:2] q.sticky[0];
  endproperty
  a_lead: assert property (p_lead)
    else $error("sticky flag lags live status too long");

  property p_enable_now;
    @(posedge clk) disable iff (!reset_n)
    (run && q.en[0] && !q.en_prev[0] && q.filt[0] && !q.mode[0])
      |=> supply_low_irq;
  endproperty
  a_enable_now: assert property (p_enable_now)
    else $error("no interrupt when enabled below threshold");

  property p_rst_mode;
    @(posedge clk) disable iff (!reset_n)
    (q.en[1] && q.mode[1] && q.filt[1]) |=> vdet_reset;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("detection reset missing while below");

  property p_irq_lp;
    @(posedge clk) disable iff (!reset_n)
    !run |=> !supply_low_irq;
  endproperty
  a_irq_lp: assert property (p_irq_lp)
    else $error("interrupt raised during low power");

  property p_hold_lp;
    @(posedge clk) disable iff (!reset_n)
    !run |=> $stable(q.live);
  endproperty
  a_hold_lp: assert property (p_hold_lp)
    else $error("live status changed during low power");

  property p_rsv_read;
    @(posedge clk) disable iff (!reset_n)
    rd_mode |=> (rdata[7:6] == 2'h0);
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("upper mode register bits read nonzero");

  property p_sticky_hold;
    @(posedge clk) disable iff (!reset_n)
    (q.sticky[0] && !clr[0]) |=> q.sticky[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky flag lost without a clear");

  property p_sticky_clr;
    @(posedge clk) disable iff (!reset_n)
    (clr[0] && !set[0]) |=> !q.sticky[0];
  endproperty
  a_sticky_clr: assert property (p_sticky_clr)
    else $error("sticky flag not cleared by a zero write");

  property p_sticky_set2;
    @(posedge clk) disable iff (!reset_n)
    (run && q.en[1] && q.filt[1]) |=> q.sticky[1];
  endproperty
  a_sticky_set2: assert property (p_sticky_set2)
    else $error("second sticky flag not set on detection");

  property p_no_sw_set1;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.sticky[0]) |-> $past(run && q.en[0] && q.filt[0]);
  endproperty
  a_no_sw_set1: assert property (p_no_sw_set1)
    else $error("first sticky flag set without detection");

  property p_set_wins2;
    @(posedge clk) disable iff (!reset_n)
    (set[1] && clr[1]) |=> q.sticky[1];
  endproperty
  a_set_wins2: assert property (p_set_wins2)
    else $error("clear beat a simultaneous second detection");

  property p_live1;
    @(posedge clk) disable iff (!reset_n)
    run |=> (q.live[0] == $past(q.en[0] && q.filt[0]));
  endproperty
  a_live1: assert property (p_live1)
    else $error("first live status does not follow comparator");

  property p_lead2;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.live[1]) |-> ##[0:2] q.sticky[1];
  endproperty
  a_lead2: assert property (p_lead2)
    else $error("second sticky flag lags live status too long");

  property p_enable_now2;
    @(posedge clk) disable iff (!reset_n)
    (run && q.en[1] && !q.en_prev[1] && q.filt[1] && !q.mode[1])
      |=> supply_low_irq;
  endproperty
  a_enable_now2: assert property (p_enable_now2)
    else $error("no interrupt when second channel enabled below");

  property p_rst_mode1;
    @(posedge clk) disable iff (!reset_n)
    (q.en[0] && q.mode[0] && q.filt[0]) |=> vdet_reset;
  endproperty
  a_rst_mode1: assert property (p_rst_mode1)
    else $error("detection reset missing for first channel");

  property p_vrst_off;
    @(posedge clk) disable iff (!reset_n)
    !(|(q.en & q.mode & q.filt)) |=> !vdet_reset;
  endproperty
  a_vrst_off: assert property (p_vrst_off)
    else $error("detection reset without a low supply");

  property p_crossing;
    @(posedge clk) disable iff (!reset_n)
    (run && q.en[0] && !q.mode[0] && (q.filt[0] != q.filt_prev[0]))
      |=> supply_low_irq;
  endproperty
  a_crossing: assert property (p_crossing)
    else $error("no interrupt on threshold crossing");

  property p_lvl_write;
    @(posedge clk) disable iff (!reset_n)
    wr_lvl |=> (chan1_threshold_sel == $past(req.wdata[1:0])) &&
      (chan2_threshold_sel == $past(req.wdata[5:4]));
  endproperty
  a_lvl_write: assert property (p_lvl_write)
    else $error("threshold select does not follow write");

  property p_mode_write;
    @(posedge clk) disable iff (!reset_n)
    wr_mode |=> (chan_monitor_on == $past({req.wdata[2], req.wdata[0]}));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("monitor enable does not follow write");

  c_irq: cover property (@(posedge clk) disable iff (!reset_n)
    supply_low_irq);
  c_vrst: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(vdet_reset));
  c_race: cover property (@(posedge clk) disable iff (!reset_n)
    set[0] && clr[0]);
  c_pend: cover property (@(posedge clk) disable iff (!reset_n)
    !run && (|ev));
  c_enable_low: cover property (@(posedge clk) disable iff (!reset_n)
    q.en[1] && !q.en_prev[1] && q.filt[1]);

endmodule

//--- verif/svm_analog_model.sv
/*
  Behavioural model of the two supply comparators that sit beside the
  monitor control block. Assumes the bench sets the supply condition of
  each channel directly.
*/
`timescale 1ns/1ns
module svm_analog_model (
  // Supply condition set by the bench.
  input wire logic [1:0] supply_low,
  // Comparator enables from the block.
  input wire logic [1:0] monitor_on,
  // Comparator outputs, bit 0 for channel 1.
  output logic [1:0] cmp_below
);
  // The comparators run free so a supply already low shows at enable.
  assign cmp_below = supply_low;
endmodule

//--- verif/tb_top.sv
/*
  Self-checking bench for the supply monitor control block. Assumes the
  package, the design and the comparator model are compiled first.
*/
`timescale 1ns/1ns
module tb_top
  import svm_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_s req = '0;
  logic [1:0] supply_low = 2'h0;
  lp_e lp_state = LP_RUN;
  logic [7:0] rdata;
  logic [1:0] cmp_below, mon_on, sel1, sel2;
  logic irq, vrst;
  int failures = 0;
  int compares = 0;
  always #5 clk = ~clk;
  supply_voltage_monitor_ctrl i_dut (
    .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .cmp_below(cmp_below), .chan_monitor_on(mon_on),
    .chan1_threshold_sel(sel1), .chan2_threshold_sel(sel2),
    .lp_state(lp_state), .supply_low_irq(irq), .vdet_reset(vrst)
  );
  svm_analog_model i_analog (
    .supply_low(supply_low), .monitor_on(mon_on), .cmp_below(cmp_below)
  );
  // --------------------------------------------------------------
  // Bus and compare tasks.
  // --------------------------------------------------------------
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e, string n);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic irq_wait(logic e);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1 seen = seen | irq;
    end
    chk("irq", {7'h0, e}, {7'h0, seen});
    if (e && !seen) results();
  endtask
  task automatic results();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------
  task automatic irq_mode();
    wr(12'hfc7, 8'h01);
    repeat (500) @(posedge clk);
    rd(12'hfc6, 8'h11, "settled");
    chk("mon on", 8'h01, {6'h0, mon_on});
    supply_low[0] <= 1'b1;
    irq_wait(1'b1);
    rd(12'hfc6, 8'h1d, "below");
    supply_low[0] <= 1'b0;
    irq_wait(1'b1);
    rd(12'hfc6, 8'h19, "recovered");
    wr(12'hfc7, 8'h00);
    rd(12'hfc6, 8'h19, "off held");
    wr(12'hfc6, 8'h11);
    rd(12'hfc6, 8'h11, "cleared");
  endtask
  task automatic enable_low();
    supply_low[1] <= 1'b1;
    repeat (8) @(posedge clk);
    rd(12'hfc6, 8'h11, "off below");
    wr(12'hfc7, 8'h04);
    irq_wait(1'b1);
    rd(12'hfc6, 8'hd1, "ch2 below");
  endtask
  task automatic reset_mode();
    wr(12'hfc6, 8'h11);
    rd(12'hfc6, 8'hd1, "set wins");
    wr(12'hfc7, 8'h0c);
    @(posedge clk);
    #1 chk("vrst on", 8'h01, {7'h0, vrst});
    repeat (20) @(posedge clk);
    #1 chk("vrst held", 8'h01, {7'h0, vrst});
    supply_low[1] <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("vrst off", 8'h00, {7'h0, vrst});
    wr(12'hfc7, 8'h04);
    wr(12'hfc7, 8'h00);
    wr(12'hfc6, 8'h11);
  endtask
  task automatic low_power();
    wr(12'hfc7, 8'h01);
    lp_state <= LP_STOP;
    supply_low[0] <= 1'b1;
    irq_wait(1'b0);
    rd(12'hfc6, 8'h11, "frozen");
    lp_state <= LP_RUN;
    irq_wait(1'b1);
    rd(12'hfc6, 8'h1d, "thawed");
  endtask
  // --------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'hfc6, 8'h20, "lvl reg");
    rd(12'hfc7, 8'h00, "mode reg");
    wr(12'hfc7, 8'hf0);
    rd(12'hfc7, 8'h30, "mode top");
    wr(12'hfc7, 8'h00);
    wr(12'hfc6, 8'h99);
    rd(12'hfc6, 8'h11, "lvl write");
    chk("sel", 8'h11, {2'h0, sel2, 2'h0, sel1});
    rd(12'h123, 8'h00, "unmapped");
    irq_mode();
    enable_low();
    reset_mode();
    low_power();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'hfc6, 8'h20, "lvl again");
    rd(12'hfc7, 8'h00, "mode again");
    chk("mon off", 8'h00, {6'h0, mon_on});
    results();
  end
  initial begin
    #900000;
    failures++;
    results();
  end
endmodule
